// ===== pioc_map.svh
`ifndef PIOC_MAP_SVH
`define PIOC_MAP_SVH

`define PIOC_AW 8
`define PIOC_OFF_OER 8'h10
`define PIOC_OFF_ODR 8'h14
`define PIOC_OFF_OSR 8'h18
`define PIOC_OFF_IFER 8'h20
`define PIOC_OFF_IFDR 8'h24
`define PIOC_OFF_IFSR 8'h28
`define PIOC_OFF_SODR 8'h30
`define PIOC_OFF_CODR 8'h34
`define PIOC_OFF_ODSR 8'h38
`define PIOC_OFF_PDSR 8'h3C
`define PIOC_OFF_IER 8'h40
`define PIOC_OFF_IDR 8'h44
`define PIOC_OFF_IMR 8'h48
`define PIOC_OFF_ISR 8'h4C

`define PIOC_RST_WORD 32'h00000000
`define PIOC_FILT_LEN 2
`define PIOC_SETTLE 3'h4

`endif

// ===== pioc_pkg.sv
package pioc_pkg;

  typedef logic [31:0] pioc_word_t;
  typedef logic [3:0] pioc_strb_t;
  typedef logic [7:0] pioc_addr_t;

  typedef enum logic [1:0] {
    PIOC_OKAY,
    PIOC_EXOKAY,
    PIOC_SLVERR,
    PIOC_DECERR
  } pioc_resp_e;

endpackage

// ===== pioc_line.sv
`timescale 1ns/100ps
module pioc_line #(
  parameter int FILT_LEN = 2
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic pin,
  input wire logic filt_en,
  output logic lvl
);

  logic s1_q;
  logic s2_q;
  logic lvl_q;
  logic [3:0] cnt_q;
  logic differ;
  logic done;

  assign differ = s2_q != lvl_q;
  assign done = cnt_q == 4'(FILT_LEN - 1);
  assign lvl = lvl_q;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk)
  begin
    s1_q <= pin;
    s2_q <= s1_q;
  end

  //////////////////////////////////////////////////////////////////////////
  // filter holds off short pulses
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      lvl_q <= 1'b0;
      cnt_q <= 4'h0;
    end
    else if (!filt_en || (differ && done))
    begin
      lvl_q <= s2_q;
      cnt_q <= 4'h0;
    end
    else if (differ)
      cnt_q <= cnt_q + 4'h1;
    else
      cnt_q <= 4'h0;
  end

endmodule

// ===== pioc_top.sv
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "pioc_map.svh"
module pioc_top #(
  parameter int FILT_LEN = `PIOC_FILT_LEN
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire pioc_pkg::pioc_addr_t awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire pioc_pkg::pioc_word_t wdata,
  input wire pioc_pkg::pioc_strb_t wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire pioc_pkg::pioc_addr_t araddr,
  input wire logic arvalid,
  output logic arready,
  output pioc_pkg::pioc_word_t rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire pioc_pkg::pioc_word_t io_select,
  input wire pioc_pkg::pioc_word_t pin_in,
  output pioc_pkg::pioc_word_t pin_out,
  output pioc_pkg::pioc_word_t pin_oe,
  output pioc_pkg::pioc_word_t periph_in,
  output logic irq
);
  import pioc_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q, irq_q;
  logic aw_full_q, w_full_q;
  logic [1:0] bresp_q, rresp_q;
  pioc_addr_t aw_addr_q;
  pioc_word_t w_data_q, rdata_q;
  pioc_strb_t w_strb_q;
  pioc_word_t osr_q, ifs_q, ods_q, imr_q, isr_q, prev_q;
  pioc_word_t pin_out_q, pin_oe_q;
  logic [2:0] settle_q;

  ////////////////////////////////////////////////////////////////////////////
  // Input sampling
  pioc_word_t lvl;
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++)
    begin : g_line
      pioc_line #(
        .FILT_LEN(FILT_LEN)
      ) u_line (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pin(pin_in[gi]),
        .filt_en(ifs_q[gi]),
        .lvl(lvl[gi])
      );
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////////////
  // Bus write channel
  logic aw_fire, w_fire, aw_have, w_have, do_wr;
  logic aw_full_d, w_full_d, bvalid_d;
  pioc_addr_t wa;
  pioc_word_t wd, wb;
  pioc_strb_t ws;
  assign aw_fire = awvalid & awready_q;
  assign w_fire = wvalid & wready_q;
  assign aw_have = aw_full_q | aw_fire;
  assign w_have = w_full_q | w_fire;
  assign do_wr = aw_have & w_have;
  assign aw_full_d = aw_have & ~do_wr;
  assign w_full_d = w_have & ~do_wr;
  assign bvalid_d = do_wr | (bvalid_q & ~bready);
  assign wa = aw_full_q ? aw_addr_q : awaddr;
  assign wd = w_full_q ? w_data_q : wdata;
  assign ws = w_full_q ? w_strb_q : wstrb;
  // Lanes without a strobe write zero, which is no effect everywhere
  assign wb = wd & {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
  logic [7:0] wa_w;
  logic hw_oer, hw_odr, hw_ifer, hw_ifdr, hw_sodr, hw_codr, hw_ier, hw_idr;
  logic wr_ok;
  assign wa_w = {wa[7:2], 2'b00};
  assign hw_oer = wa_w == `PIOC_OFF_OER;
  assign hw_odr = wa_w == `PIOC_OFF_ODR;
  assign hw_ifer = wa_w == `PIOC_OFF_IFER;
  assign hw_ifdr = wa_w == `PIOC_OFF_IFDR;
  assign hw_sodr = wa_w == `PIOC_OFF_SODR;
  assign hw_codr = wa_w == `PIOC_OFF_CODR;
  assign hw_ier = wa_w == `PIOC_OFF_IER;
  assign hw_idr = wa_w == `PIOC_OFF_IDR;
  assign wr_ok = hw_oer | hw_odr | hw_ifer | hw_ifdr | hw_sodr | hw_codr
    | hw_ier | hw_idr;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= PIOC_OKAY;
    end
    else
    begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      awready_q <= ~aw_full_d & ~bvalid_d;
      wready_q <= ~w_full_d & ~bvalid_d;
      bvalid_q <= bvalid_d;
      if (do_wr)
        bresp_q <= wr_ok ? PIOC_OKAY : PIOC_SLVERR;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (aw_fire)
      aw_addr_q <= awaddr;
    if (w_fire)
    begin
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus read channel
  logic ar_fire, rvalid_d, rd_ok;
  logic [7:0] ra;
  logic hr_osr, hr_ifsr, hr_odsr, hr_pdsr, hr_imr, hr_isr;
  pioc_word_t rd_mux;
  assign ar_fire = arvalid & arready_q;
  assign rvalid_d = ar_fire | (rvalid_q & ~rready);
  assign ra = {araddr[7:2], 2'b00};
  assign hr_osr = ra == `PIOC_OFF_OSR;
  assign hr_ifsr = ra == `PIOC_OFF_IFSR;
  assign hr_odsr = ra == `PIOC_OFF_ODSR;
  assign hr_pdsr = ra == `PIOC_OFF_PDSR;
  assign hr_imr = ra == `PIOC_OFF_IMR;
  assign hr_isr = ra == `PIOC_OFF_ISR;
  assign rd_ok = hr_osr | hr_ifsr | hr_odsr | hr_pdsr | hr_imr | hr_isr;
  assign rd_mux = ({32{hr_osr}} & osr_q) | ({32{hr_ifsr}} & ifs_q)
    | ({32{hr_odsr}} & ods_q) | ({32{hr_pdsr}} & lvl)
    | ({32{hr_imr}} & imr_q) | ({32{hr_isr}} & isr_q);

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rresp_q <= PIOC_OKAY;
      rdata_q <= `PIOC_RST_WORD;
    end
    else
    begin
      arready_q <= ~rvalid_d;
      rvalid_q <= rvalid_d;
      if (ar_fire)
      begin
        rdata_q <= rd_mux;
        rresp_q <= rd_ok ? PIOC_OKAY : PIOC_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line state
  pioc_word_t w_oer, w_odr, w_ifer, w_ifdr, w_sodr, w_codr, w_ier, w_idr;
  pioc_word_t osr_d, ifs_d, ods_d, imr_d, isr_d, edges;
  logic settled, isr_rd;

  assign w_oer = {32{do_wr & hw_oer}} & wb;
  assign w_odr = {32{do_wr & hw_odr}} & wb;
  assign w_ifer = {32{do_wr & hw_ifer}} & wb;
  assign w_ifdr = {32{do_wr & hw_ifdr}} & wb;
  assign w_sodr = {32{do_wr & hw_sodr}} & wb;
  assign w_codr = {32{do_wr & hw_codr}} & wb;
  assign w_ier = {32{do_wr & hw_ier}} & wb;
  assign w_idr = {32{do_wr & hw_idr}} & wb;

  assign osr_d = (osr_q | w_oer) & ~w_odr;
  assign ifs_d = (ifs_q | w_ifer) & ~w_ifdr;
  assign ods_d = (ods_q | w_sodr) & ~w_codr;
  assign imr_d = (imr_q | w_ier) & ~w_idr;

  // Filter and change-detect flops reset to zero, sync flops are not reset; ignore edges until they settle
  assign settled = settle_q == `PIOC_SETTLE;
  assign isr_rd = ar_fire & hr_isr;
  // edges win over the read clear
  assign edges = (lvl ^ prev_q) & {32{settled}};
  assign isr_d = (isr_rd ? `PIOC_RST_WORD : isr_q) | edges;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      osr_q <= `PIOC_RST_WORD;
      ifs_q <= `PIOC_RST_WORD;
      ods_q <= `PIOC_RST_WORD;
      imr_q <= `PIOC_RST_WORD;
      isr_q <= `PIOC_RST_WORD;
      prev_q <= `PIOC_RST_WORD;
      settle_q <= 3'h0;
    end
    else
    begin
      osr_q <= osr_d;
      ifs_q <= ifs_d;
      ods_q <= ods_d;
      imr_q <= imr_d;
      isr_q <= isr_d;
      prev_q <= lvl;
      if (!settled)
        settle_q <= settle_q + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive and interrupt
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pin_out_q <= `PIOC_RST_WORD;
      pin_oe_q <= `PIOC_RST_WORD;
      irq_q <= 1'b0;
    end
    else
    begin
      pin_out_q <= ods_q;
      pin_oe_q <= osr_q & io_select;
      irq_q <= |(isr_d & imr_d);
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign pin_out = pin_out_q;
  assign pin_oe = pin_oe_q;
  // filtered level also feeds the peripheral
  assign periph_in = lvl;
  assign irq = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_set_ods;
    do_wr && hw_sodr |=> ((ods_q & $past(wb)) == $past(wb));
  endproperty
  a_set_ods: assert property (p_set_ods) else $error("set latch");
  property p_clr_ods;
    do_wr && hw_codr |=> ((ods_q & $past(wb)) == 32'h00000000)
      && ((ods_q & ~$past(wb)) == ($past(ods_q) & ~$past(wb)));
  endproperty
  a_clr_ods: assert property (p_clr_ods) else $error("clear latch");
  property p_drive;
    ##1 (pin_oe_q == $past(osr_q & io_select)) && (pin_out_q == $past(ods_q));
  endproperty
  a_drive: assert property (p_drive) else $error("pin drive");
  property p_filt;
    do_wr && (hw_ifer || hw_ifdr) |=>
      (ifs_q == ($past(hw_ifer) ? ($past(ifs_q) | $past(wb))
                                : ($past(ifs_q) & ~$past(wb))));
  endproperty
  a_filt: assert property (p_filt) else $error("filter status");
  property p_mask;
    do_wr && hw_idr |=> ((imr_q & $past(wb)) == 32'h00000000);
  endproperty
  a_mask: assert property (p_mask) else $error("mask kept");
  property p_isr_clr;
    isr_rd |=> (isr_q == $past(edges));
  endproperty
  a_isr_clr: assert property (p_isr_clr) else $error("read clear");
  property p_edge;
    settled && (lvl != prev_q) |=> ((isr_q & $past(lvl ^ prev_q))
      == $past(lvl ^ prev_q));
  endproperty
  a_edge: assert property (p_edge) else $error("edge lost");
  property p_irq;
    ##1 (irq_q == |(isr_q & imr_q));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt line");
  property p_pds;
    ar_fire && hr_pdsr |=> rvalid_q && (rdata_q == $past(lvl));
  endproperty
  a_pds: assert property (p_pds) else $error("pin level read");
  // Response stands until the master takes it
  property p_bresp;
    do_wr || (bvalid_q && !bready) |=> bvalid_q;
  endproperty
  a_bresp: assert property (p_bresp) else $error("write response");
  c_irq: cover property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(irq_q));
  c_isr_rd: cover property (@(posedge sys_clk) disable iff (!rst_n)
    isr_rd && (isr_q != 32'h00000000));
  c_drive: cover property (@(posedge sys_clk) disable iff (!rst_n)
    (pin_oe_q & pin_out_q) != 32'h00000000);
endmodule

// ===== pioc_pin_model.sv
`timescale 1ns/100ps
module pioc_pin_model (
  input wire pioc_pkg::pioc_word_t pin_out,
  input wire pioc_pkg::pioc_word_t pin_oe,
  input wire pioc_pkg::pioc_word_t ext_lvl,
  output pioc_pkg::pioc_word_t pin_lvl
);
  import pioc_pkg::*;
  // Driven lines follow the block, the rest the external devices
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule

// ===== pio_output_data_and_pin_event_control_tb_top.sv
`timescale 1ns/100ps
module pio_output_data_and_pin_event_control_tb_top;
  import pioc_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  pioc_addr_t awaddr = 8'h00;
  pioc_addr_t araddr = 8'h00;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  pioc_word_t wdata = 32'h0;
  pioc_strb_t wstrb = 4'hF;
  pioc_word_t io_select = 32'h0;
  pioc_word_t ext_lvl = 32'h12340000;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  pioc_word_t rdata, pin_in, pin_out, pin_oe, periph_in;
  int fail_count = 0;
  int checked = 0;
  int cyc = 0;

  always #12.5 sys_clk = ~sys_clk;

  pioc_top u_pioc_top (.sys_clk(sys_clk), .rst_n(rst_n), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .io_select(io_select), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .periph_in(periph_in), .irq(irq));

  pioc_pin_model u_pioc_pin_model (.pin_out(pin_out), .pin_oe(pin_oe),
    .ext_lvl(ext_lvl), .pin_lvl(pin_in));

  //////////////////////////////////////////////////////////////////////
  task automatic chk(input pioc_word_t got, input pioc_word_t exp,
                     input string what);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input pioc_addr_t a, input pioc_word_t d,
                    input pioc_resp_e er = PIOC_OKAY);
    bit aw_done;
    bit w_done;
    aw_done = 0;
    w_done = 0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Each channel released at its own handshake
    while (!(aw_done && w_done))
    begin
      @(posedge sys_clk);
      if (awvalid && awready) aw_done = 1;
      if (wvalid && wready) w_done = 1;
      awvalid <= !aw_done;
      wvalid <= !w_done;
    end
    while (!bvalid) @(posedge sys_clk);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er}, "write response");
  endtask

  task automatic rd(input pioc_addr_t a, input pioc_word_t exp,
                    input pioc_word_t m = 32'hFFFFFFFF,
                    input pioc_resp_e er = PIOC_OKAY);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge sys_clk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge sys_clk);
    rready <= 1'b0;
    chk({30'h0, rresp}, {30'h0, er}, "read response");
    if (er == PIOC_OKAY) chk(rdata & m, exp & m, "read data");
  endtask

  // Covers sync, filter and change-detect latency
  task automatic settle();
    repeat (8) @(posedge sys_clk);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fail_count++;
      $display("[FAIL] %0t timeout", $time);
      conclude();
    end
  end

  initial
  begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    chk({31'h0, irq}, 32'h0, "irq after reset");
    rd(8'h28, 32'h0);
    rd(8'h38, 32'h0);
    rd(8'h48, 32'h0);
    rd(8'h18, 32'h0);
    $display("test reset_values done");
    // Back-to-back set and clear, zero bits ignored
    wr(8'h30, 32'hA5A50F0F);
    wr(8'h34, 32'h00000F01);
    wr(8'h30, 32'h0);
    wr(8'h34, 32'h0);
    rd(8'h38, 32'hA5A5000E);
    chk(pin_out, 32'hA5A5000E, "latch on pins");
    $display("test set_clear done");
    io_select <= 32'h0000000F;
    wr(8'h10, 32'h000000FF);
    rd(8'h18, 32'h000000FF);
    settle();
    chk(pin_oe, 32'h0000000F, "drive only selected outputs");
    rd(8'h3C, 32'h1234000E);
    chk(periph_in, 32'h1234000E, "peripheral level");
    wr(8'h14, 32'h000000F0);
    rd(8'h18, 32'h0000000F);
    $display("test pin_drive done");
    wr(8'h20, 32'h0000FFFF);
    wr(8'h24, 32'h000000FF);
    rd(8'h28, 32'h0000FF00);
    rd(8'h4C, 32'h0, 32'h0);
    // One-cycle glitch: filtered line 8 holds, line 16 reports
    @(posedge sys_clk);
    ext_lvl <= 32'h12350100;
    @(posedge sys_clk);
    ext_lvl <= 32'h12340000;
    settle();
    rd(8'h4C, 32'h00010000, 32'h00010100);
    $display("test filter done");
    wr(8'h40, 32'h00010000);
    rd(8'h48, 32'h00010000);
    // Line 16 stays under peripheral control
    ext_lvl <= 32'h12350000;
    settle();
    chk({31'h0, irq}, 32'h1, "irq raised");
    rd(8'h4C, 32'h00010000, 32'h00010000);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0, "irq cleared by read");
    rd(8'h4C, 32'h0);
    wr(8'h44, 32'h00010000);
    rd(8'h48, 32'h0);
    ext_lvl <= 32'h12340000;
    settle();
    chk({31'h0, irq}, 32'h0, "irq masked");
    rd(8'h4C, 32'h00010000, 32'h00010000);
    $display("test interrupts done");
    wr(8'h38, 32'hFFFFFFFF, PIOC_SLVERR);
    rd(8'h30, 32'h0, 32'h0, PIOC_SLVERR);
    rd(8'h80, 32'h0, 32'h0, PIOC_SLVERR);
    rd(8'h38, 32'hA5A5000E);
    $display("test errors done");
    conclude();
  end
endmodule
